// ### hdl/lgc_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// - black and white fixed, two grays adjustable
// - grays from upper and lower map nibbles
// - contrast source: line, pixel, lcd, reserved
// - contrast frequency is source over 256
// - contrast runs only while enable set
// - pulse width from eight-bit field
// - self refresh follows its control bit
// - refresh parks shift clock, data low
// - eight by sixteen buffer feeds panel
// - request refill at trigger mark level
// - each refill loads burst length words
module lgc_ctrl (
    // apb clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // timing enables from the rest of the controller
    input  wire logic                 line_tick,
    input  wire logic                 pix_tick,
    input  wire logic                 lcd_tick,
    input  wire lgc_pkg::lgc_panel_t  panel_in,
    input  wire logic [1:0]           pixel_code,
    // dma fill
    input  wire logic                 fill_valid,
    input  wire logic [15:0]          fill_data,
    output logic                      fill_ready,
    output logic                      refill_req,
    // panel side
    input  wire logic                 drain_ready,
    output logic                      drain_valid,
    output logic [15:0]               drain_data,
    output lgc_pkg::lgc_panel_t       panel_out,
    output logic [3:0]                gray_density,
    output logic                      contrast_pulse_out
);
    import lgc_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0]  gray_palette_map_r;      // two gray densities
    logic [15:0] contrast_pwm_control_r;  // source, enable, width
    logic [7:0]  self_refresh_control_r;  // refresh on in bit 7
    logic [7:0]  pixel_dma_control_r;     // burst and mark
    logic [31:0] rdata_nxt;               // read mux
    logic        hit;                     // address decodes
    logic        acc;                     // access phase
    logic        wr;                      // write strobe
    logic [3:0]  level;                   // buffer occupancy
    logic        req_raw;                 // buffer request
    logic        pulse_raw;               // modulator output
    logic        dv_raw;                  // buffer valid
    logic [15:0] dd_raw;                  // buffer head word
    logic        fr_raw;                  // buffer ready
    lgc_gray_t   gray;                    // map split into fields
    logic [3:0]  gray_nxt;                // density for current pixel
    lgc_panel_t  panel_nxt;               // panel pins next
    logic        refresh_on;              // self refresh active

    assign acc = psel && penable;
    assign wr  = acc && pwrite;
    assign hit = (paddr == LGC_OFF_GRAY) || (paddr == LGC_OFF_PWM)
              || (paddr == LGC_OFF_REFRESH) || (paddr == LGC_OFF_DMA)
              || (paddr == LGC_OFF_STATUS);

    // ************************************************************
    // apb: one wait state, error on unmapped address
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // answer registered, so one wait state after setup
            pready  <= psel && !pready && !penable ? 1'b0 : psel && !pready;
            pslverr <= psel && !pready && penable && !hit;
        end
    end

    // register writes land on the pready edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gray_palette_map_r     <= LGC_GRAY_RST;
            contrast_pwm_control_r <= LGC_PWM_RST;
            self_refresh_control_r <= LGC_REF_RST;
            pixel_dma_control_r    <= LGC_DMA_RST;
        end else if (wr && pready) begin
            unique case (paddr)
                LGC_OFF_GRAY:    gray_palette_map_r <= pwdata[7:0];
                // reserved bits 15:11 kept zero
                LGC_OFF_PWM:     contrast_pwm_control_r <= {5'h00, pwdata[10:0]};
                // only the refresh bit is stored
                LGC_OFF_REFRESH: self_refresh_control_r <=
                                 {pwdata[LGC_REF_BIT], 7'h00};
                // bit 3 reserved, reads zero
                LGC_OFF_DMA:     pixel_dma_control_r <= {pwdata[7:4], 1'b0, pwdata[2:0]};
                default:         ;
            endcase
        end
    end

    // read mux, status shows live buffer state
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (paddr)
            LGC_OFF_GRAY:    rdata_nxt = {24'h00_0000, gray_palette_map_r};
            LGC_OFF_PWM:     rdata_nxt = {16'h0000, contrast_pwm_control_r};
            LGC_OFF_REFRESH: rdata_nxt = {24'h00_0000, self_refresh_control_r};
            LGC_OFF_DMA:     rdata_nxt = {24'h00_0000, pixel_dma_control_r};
            LGC_OFF_STATUS:  rdata_nxt = {27'h000_0000, req_raw, level};
            default:         rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !pwrite) begin
            prdata <= rdata_nxt;
        end
    end

    // ************************************************************
    // contrast modulator
    // ************************************************************
    lgc_contrast_pwm u_pwm (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (contrast_pwm_control_r[LGC_CEN_BIT]),
        .src       (lgc_src_t'(contrast_pwm_control_r[LGC_SRC_LSB +: 2])),
        .width     (contrast_pwm_control_r[7:0]),
        .line_tick (line_tick),
        .pix_tick  (pix_tick),
        .lcd_tick  (lcd_tick),
        .pulse_r   (pulse_raw)
    );

    // ************************************************************
    // pixel buffer; software keeps burst+mark within depth
    // ************************************************************
    lgc_pixel_buffer u_buf (
        .pclk            (pclk),
        .presetn         (presetn),
        .burst_words     (pixel_dma_control_r[LGC_BL_LSB +: 4]),
        .low_water_words (pixel_dma_control_r[2:0]),
        .fill_valid      (fill_valid),
        .fill_data       (fill_data),
        .fill_ready      (fr_raw),
        .drain_ready     (drain_ready),
        .drain_valid     (dv_raw),
        .drain_data      (dd_raw),
        .refill_req_r    (req_raw),
        .level_r         (level)
    );

    assign fill_ready  = fr_raw;
    assign drain_valid = dv_raw;
    assign drain_data  = dd_raw;

    // ************************************************************
    // gray mapping: 00 black, 11 white fixed, middle codes mapped
    // ************************************************************
    assign gray = gray_palette_map_r;
    always_comb begin
        unique case (pixel_code)
            2'h0: gray_nxt = 4'h0;
            2'h1: gray_nxt = gray.first_gray_density;  // low nibble
            2'h2: gray_nxt = gray.second_gray_density; // high nibble
            2'h3: gray_nxt = 4'hF;
        endcase
    end

    // ************************************************************
    // panel pins; refresh parks clock and data, pulses pass
    // ************************************************************
    assign refresh_on = self_refresh_control_r[LGC_REF_BIT];
    always_comb begin
        panel_nxt = panel_in;
        if (refresh_on) begin
            panel_nxt.shift_clock = 1'b0;
            panel_nxt.data_lines  = 8'h00;
        end
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            panel_out          <= '0;
            gray_density       <= 4'h0;
            contrast_pulse_out <= 1'b0;
            refill_req         <= 1'b0;
        end else begin
            panel_out          <= panel_nxt;
            gray_density       <= gray_nxt;
            contrast_pulse_out <= pulse_raw;
            refill_req         <= req_raw;
        end
    end

    ref_park_a: assert property (@(posedge pclk) disable iff (!presetn)
        refresh_on |=> (!panel_out.shift_clock && panel_out.data_lines == 8'h00))
        else $error("panel not parked in refresh");
    ref_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> panel_out.line_pulse == $past(panel_in.line_pulse))
        else $error("line pulse not passed");
    gray_fix_a: assert property (@(posedge pclk) disable iff (!presetn)
        pixel_code == 2'h3 |=> gray_density == 4'hF) else $error("white not fixed");
    gray_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        pixel_code == 2'h2 |=> gray_density == $past(gray_palette_map_r[7:4]))
        else $error("upper nibble not used");
endmodule

// ### hdl/lgc_pkg.sv
package lgc_pkg;
    // ************************************************************
    // register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [11:0] LGC_OFF_GRAY     = 12'h000;  // gray_palette_map
    localparam logic [11:0] LGC_OFF_PWM      = 12'h004;  // contrast_pwm_control
    localparam logic [11:0] LGC_OFF_REFRESH  = 12'h008;  // self_refresh_control
    localparam logic [11:0] LGC_OFF_DMA      = 12'h00C;  // pixel_dma_control
    localparam logic [11:0] LGC_OFF_STATUS   = 12'h010;  // buffer level, read only

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int LGC_SRC_LSB     = 9;   // contrast_clock_select 10:9
    localparam int LGC_CEN_BIT     = 8;   // contrast_enable
    localparam int LGC_REF_BIT     = 7;   // self refresh on
    localparam int LGC_BL_LSB      = 4;   // refill_burst_length 7:4
    localparam int LGC_SECOND_LSB  = 4;   // second_gray_density 7:4

    // ************************************************************
    // reset values and sizes
    // ************************************************************
    localparam logic [7:0]  LGC_GRAY_RST = 8'h00;
    localparam logic [15:0] LGC_PWM_RST  = 16'h0000;
    localparam logic [7:0]  LGC_REF_RST  = 8'h00;
    localparam logic [7:0]  LGC_DMA_RST  = 8'h12;    // burst 1, mark 2
    localparam int          LGC_DEPTH    = 8;        // pixel buffer words
    localparam int          LGC_WORD_W   = 16;       // pixel word width

    // ************************************************************
    // clock sources and carriers
    // ************************************************************
    typedef enum logic [1:0] {
        LGC_SRC_LINE = 2'h0,
        LGC_SRC_PIX  = 2'h1,
        LGC_SRC_LCD  = 2'h2,
        LGC_SRC_RSV  = 2'h3
    } lgc_src_t;

    typedef struct packed {
        logic       shift_clock;   // panel_shift_clock
        logic [7:0] data_lines;    // panel_data_lines
        logic       frame_pulse;   // frame_pulse
        logic       line_pulse;    // line_pulse
    } lgc_panel_t;

    typedef struct packed {
        logic [3:0] second_gray_density;  // upper nibble of the map
        logic [3:0] first_gray_density;   // lower nibble of the map
    } lgc_gray_t;
endpackage

// ### hdl/lgc_contrast_pwm.sv
`timescale 1ns/10ps
// 256-count contrast modulator on a selectable enable
module lgc_contrast_pwm (
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // control
    input  wire logic            enable,
    input  wire lgc_pkg::lgc_src_t src,
    input  wire logic [7:0]      width,
    // source enables
    input  wire logic            line_tick,
    input  wire logic            pix_tick,
    input  wire logic            lcd_tick,
    // output
    output logic                 pulse_r
);
    import lgc_pkg::*;

    logic [7:0] count_r;  // period counter, steps on the source, cleared while disabled
    logic       step;     // one count of the selected source

    // ************************************************************
    // source select
    // ************************************************************
    always_comb begin
        unique case (src)
            LGC_SRC_LINE: step = line_tick;
            LGC_SRC_PIX:  step = pix_tick;
            LGC_SRC_LCD:  step = lcd_tick;
            LGC_SRC_RSV:  step = 1'b0;       // reserved code parks counter
        endcase
    end

    // counter wraps each 256 steps, giving source rate / 256
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 8'h00;
        end else if (!enable) begin
            count_r <= 8'h00;
        end else if (step) begin
            count_r <= count_r + 8'h01;
        end
    end

    // output high while count below width, low when off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= enable && (count_r < width);
        end
    end

    pwm_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !enable |=> !pulse_r) else $error("contrast pulse while disabled");
    pwm_wid_a: assert property (@(posedge pclk) disable iff (!presetn)
        (enable && $stable(enable) && count_r >= width) |=> !pulse_r)
        else $error("contrast pulse past width");
    pwm_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (enable && step && $past(enable)) |=> count_r == $past(count_r) + 8'h01)
        else $error("period counter missed a step");
endmodule

// ### hdl/lgc_pixel_buffer.sv
`timescale 1ns/10ps
// 8 x 16 pixel buffer with low-water refill request
module lgc_pixel_buffer (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // configuration
    input  wire logic [3:0]  burst_words,
    input  wire logic [2:0]  low_water_words,
    // dma fill side
    input  wire logic        fill_valid,
    input  wire logic [15:0] fill_data,
    output logic             fill_ready,
    // panel drain side
    input  wire logic        drain_ready,
    output logic             drain_valid,
    output logic [15:0]      drain_data,
    // state
    output logic             refill_req_r,
    output logic [3:0]       level_r
);
    import lgc_pkg::*;

    logic [LGC_WORD_W-1:0] mem_r [LGC_DEPTH];  // buffer words
    logic [2:0]            wptr_r;              // write index
    logic [2:0]            rptr_r;              // read index
    logic [3:0]            left_r;              // words still due in burst
    logic                  push;
    logic                  pop;

    assign fill_ready  = (left_r != 4'h0) && (level_r != 4'(LGC_DEPTH));
    assign push        = fill_valid && fill_ready;
    assign drain_valid = level_r != 4'h0;
    assign pop         = drain_valid && drain_ready;
    assign drain_data  = mem_r[rptr_r];

    // ************************************************************
    // storage
    // ************************************************************
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_r[wptr_r] <= fill_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_r  <= 3'h0;
            rptr_r  <= 3'h0;
            level_r <= 4'h0;
        end else begin
            if (push) wptr_r <= wptr_r + 3'h1;
            if (pop) rptr_r <= rptr_r + 3'h1;
            level_r <= level_r + {3'h0, push} - {3'h0, pop};
        end
    end

    // refill cycle: request at the mark, then take one burst
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_r       <= 4'h0;
            refill_req_r <= 1'b0;
        end else if (left_r == 4'h0 && !refill_req_r
                     && level_r <= {1'b0, low_water_words}) begin
            refill_req_r <= 1'b1;
            left_r       <= burst_words;
        end else begin
            if (push) left_r <= left_r - 4'h1;
            if (push && left_r == 4'h1) refill_req_r <= 1'b0;
        end
    end

    buf_full_a: assert property (@(posedge pclk) disable iff (!presetn)
        level_r <= 4'(LGC_DEPTH)) else $error("pixel buffer overflow");
    buf_mark_a: assert property (@(posedge pclk) disable iff (!presetn)
        (left_r == 4'h0 && !refill_req_r && level_r <= {1'b0, low_water_words})
        |=> refill_req_r) else $error("refill request not raised at mark");
    buf_burst_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(refill_req_r) |-> left_r == $past(burst_words))
        else $error("burst length not loaded");
endmodule

// ### verification/lgc_panel_model.sv
`timescale 1ns/10ps
// ************************************************************
// panel sink: takes buffer words, can be held off by the bench
// ************************************************************
module lgc_panel_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // stall request from the bench
    input  wire logic        hold,
    // buffer drain side
    input  wire logic        drain_valid,
    input  wire logic [15:0] drain_data,
    output logic             drain_ready,
    // record of taken words
    output logic [15:0]      last_word,
    output logic [3:0]       taken
);
    logic [1:0] phase_r;  // slow-panel pacing

    // ready drops one cycle in four even when free, like a slow panel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r     <= 2'h0;
            drain_ready <= 1'b0;
        end else begin
            phase_r     <= phase_r + 2'h1;
            drain_ready <= !hold && (phase_r != 2'h3);
        end
    end

    // a word counts only when both sides agree at the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_word <= 16'h0000;
            taken     <= 4'h0;
        end else if (drain_valid && drain_ready) begin
            last_word <= drain_data;
            taken     <= taken + 4'h1;
        end
    end
endmodule

// ### verification/tb_lgc_ctrl.sv
`timescale 1ns/10ps
// ************************************************************
// self-checking bench: registers, grays, contrast, refresh, refill
// ************************************************************
module tb_lgc_ctrl;
    import lgc_pkg::*;
    typedef struct packed {
        logic [15:0] pwm;    // contrast register value
        logic [2:0]  ticks;  // {lcd, pix, line} enables held high
        logic [31:0] highs;  // expected high cycles in 512
    } lgc_row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic        line_tick = 1'b0, pix_tick = 1'b0, lcd_tick = 1'b0;
    lgc_panel_t  panel_in = '0, panel_out;
    logic [1:0]  pixel_code = 2'h0;
    logic        fill_valid = 1'b0, fill_ready, refill_req;
    logic [15:0] fill_data = 16'h0000, drain_data, last_word;
    logic        drain_ready, drain_valid, hold = 1'b1;
    logic [3:0]  gray_density, taken;
    logic        contrast_pulse_out;
    int          fail_count = 0, num_checks = 0, cyc = 0, n, k;
    lgc_row_t    rows [5] = '{'{16'h0340, 3'h2, 32'd128}, '{16'h0580, 3'h4, 32'd256},
                              '{16'h0120, 3'h1, 32'd64},  '{16'h0040, 3'h2, 32'd0},
                              '{16'h0740, 3'h7, 32'd512}};  // reserved source parks
    logic [3:0]  gray_exp [4] = '{4'h0, 4'h5, 4'hA, 4'hF};

    lgc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_tick(line_tick), .pix_tick(pix_tick), .lcd_tick(lcd_tick),
        .panel_in(panel_in), .pixel_code(pixel_code), .fill_valid(fill_valid),
        .fill_data(fill_data), .fill_ready(fill_ready), .refill_req(refill_req),
        .drain_ready(drain_ready), .drain_valid(drain_valid), .drain_data(drain_data),
        .panel_out(panel_out), .gray_density(gray_density),
        .contrast_pulse_out(contrast_pulse_out));
    lgc_panel_model panel (.pclk(pclk), .presetn(presetn), .hold(hold),
        .drain_valid(drain_valid), .drain_data(drain_data), .drain_ready(drain_ready),
        .last_word(last_word), .taken(taken));

    // ************************************************************
    // clock, hang guard, shared tasks
    // ************************************************************
    always #25 pclk = ~pclk;

    // a run far past the expected length is a hang
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; waits for pready, only the hang guard ends a wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stop_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, LGC_OFF_DMA, 32'h0);
        check("dma reset", rd, {24'h0, LGC_DMA_RST});
        apb(1'b0, LGC_OFF_PWM, 32'h0);
        check("pwm reset", rd, {16'h0, LGC_PWM_RST});
        // empty buffer is below the reset mark, so a request is up
        check("reset request", {31'h0, refill_req}, 32'h1);
        apb(1'b1, 12'h020, 32'hFF);
        check("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b1, LGC_OFF_GRAY, 32'hA5);
        apb(1'b0, LGC_OFF_GRAY, 32'h0);
        check("gray map", rd, 32'hA5);
        check("mapped no error", {31'h0, err}, 32'h0);
        // contrast rows: source, enable, width, period of 256
        foreach (rows[i]) begin
            apb(1'b1, LGC_OFF_PWM, {16'h0, rows[i].pwm});
            {lcd_tick, pix_tick, line_tick} <= rows[i].ticks;
            repeat (8) @(posedge pclk);
            n = 0;
            repeat (512) begin
                @(posedge pclk);
                n = n + int'(contrast_pulse_out === 1'b1);
            end
            check("contrast highs", n, rows[i].highs);
        end
        // fixed black and white, two adjustable grays
        for (k = 0; k < 4; k++) begin
            pixel_code <= k[1:0];
            repeat (3) @(posedge pclk);
            check("gray density", gray_density, gray_exp[k]);
        end
        // self refresh parks shift clock and data, pulses pass
        panel_in <= '{1'b1, 8'hFF, 1'b1, 1'b1};
        apb(1'b1, LGC_OFF_REFRESH, 32'h80);
        repeat (3) @(posedge pclk);
        check("refresh pins", panel_out, 11'h003);
        apb(1'b1, LGC_OFF_REFRESH, 32'h00);
        repeat (3) @(posedge pclk);
        check("normal pins", panel_out, 11'h7FF);
        // burst 4, mark 2: sum stays within eight; the reset setting has
        // one word still due, so one stale word lands before the burst of 4
        apb(1'b1, LGC_OFF_DMA, 32'h42);
        fill_valid <= 1'b1;
        fill_data  <= 16'hA000;
        k = 0;
        repeat (16) begin
            @(posedge pclk);
            if (fill_valid && fill_ready === 1'b1) begin
                k = k + 1;
                fill_data <= 16'hA000 + 16'(k);
            end
        end
        fill_valid <= 1'b0;
        check("burst words", k, 32'd5);
        check("request after burst", {31'h0, refill_req}, 32'h0);
        apb(1'b0, LGC_OFF_STATUS, 32'h0);
        check("level after burst", rd, 32'h05);
        hold <= 1'b0;
        n = 0;
        while (taken !== 4'h5 && n < 100) begin
            @(posedge pclk);
            n = n + 1;
        end
        repeat (3) @(posedge pclk);
        check("last drained", last_word, 16'hA004);
        apb(1'b0, LGC_OFF_STATUS, 32'h0);
        check("empty requests", rd, 32'h10);
        stop_test();
    end
endmodule
